// ### nsld_lamp_driver.sv
// Top of the network status lamp driver
// How it works
// (RULE1) Module lamp steady green when operational
// (RULE2) Module lamp flashes green when unconfigured
// (RULE3) Self-test module lamp: green, red, green hold
// (RULE4) Self-test network lamp: green, red, dark
// (RULE5) Module lamp flashes red on recoverable fault
// (RULE6) Module lamp steady red on unrecoverable fault
// (RULE7) Network steady green when address and connection
// (RULE8) Network flashes green with address, no connection
// (RULE9) Network flashes red on owner connection timeout
// (RULE10) Green returns only after all timeouts cleared
// (RULE11) Network steady red on duplicate address
// (RULE12) Network dark without an address
// (RULE13) Link lamp follows Ethernet link state
// (RULE14) Activity lamp flickers with frame traffic
// (RULE15) Flashing is 500 ms lit, 500 ms dark
// (RULE16) Flicker toggles every 50 ms under load
// (RULE17) Millisecond tick times all; reset restarts test
// (RULE18) Network precedence: test, dup, timeout, conn, none; code ranks no address (dark) after dup, above timeout
`timescale 1ns/1ns
module nsld_lamp_driver #(
  parameter int unsigned TICK_DIVIDE = nsld_pkg::TICK_CYCLES,
  parameter int unsigned STEP_MS     = nsld_pkg::SELFTEST_STEP_MS,
  parameter int unsigned FLASH_MS    = nsld_pkg::FLASH_HALF_MS,
  parameter int unsigned FLICKER_MS  = nsld_pkg::FLICKER_HALF_MS
) (
  input  wire logic                       clock_in,
  input  wire logic                       reset_n_in,
  input  wire logic                       selftest_done_in,
  input  wire nsld_pkg::nsld_module_type  module_in,
  input  wire nsld_pkg::nsld_network_type network_in,
  input  wire logic                       link_up_in,
  input  wire logic                       frame_activity_in,
  output nsld_pkg::nsld_duo_type          module_health_lamp_out,
  output nsld_pkg::nsld_duo_type          network_health_lamp_out,
  output logic                            link_lamp_out,
  output logic                            activity_lamp_out
);

  // Refuse counts that the 16-bit counters cannot hold
  initial
  begin
    if (STEP_MS < 1 || STEP_MS > 65535)
      $error("STEP_MS out of range");
    if (FLASH_MS < 1 || FLASH_MS > 65535)
      $error("FLASH_MS out of range");
    if (FLICKER_MS < 1 || FLICKER_MS > 65535)
      $error("FLICKER_MS out of range");
  end

  localparam logic [15:0] STEP_LAST    = 16'(STEP_MS - 1);    // Last ms of a test step
  localparam logic [15:0] FLASH_LAST   = 16'(FLASH_MS - 1);   // Last ms of a flash half
  localparam logic [15:0] FLICKER_LAST = 16'(FLICKER_MS - 1); // Last ms of flicker half

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [9:0] raw_flags;  // All pin inputs except link packed
  logic [9:0] sync_flags; // After two flops
  nsld_pkg::nsld_module_type  mod_s;  // Synchronised module flags
  nsld_pkg::nsld_network_type net_s;  // Synchronised network flags
  logic                       done_s; // Synchronised self-test done
  logic                       link_s; // Synchronised link
  logic                       act_s;  // Synchronised activity

  assign raw_flags = {selftest_done_in, module_in, network_in, frame_activity_in};

  nsld_sync #(.WIDTH(10)) u_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (raw_flags),
    .sync_out   (sync_flags)
  );

  // Link comes through its own pair of flops
  logic link_meta_reg; // First stage for link
  logic link_reg;      // Second stage for link
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      link_meta_reg <= 1'b0;
      link_reg      <= 1'b0;
    end
    else
    begin
      link_meta_reg <= link_up_in;
      link_reg      <= link_meta_reg;
    end
  end

  assign done_s = sync_flags[9];
  assign mod_s  = sync_flags[8:5];
  assign net_s  = sync_flags[4:1];
  assign act_s  = sync_flags[0];
  assign link_s = link_reg;

  // ****************************************************************
  // Millisecond timebase
  // ****************************************************************
  logic ms_tick; // One-cycle pulse per ms

  nsld_tick_divider #(.DIVIDE(TICK_DIVIDE)) u_tick ( // [RULE17]
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .tick_out   (ms_tick)
  );

  // ****************************************************************
  // Self-test sequencer
  // ****************************************************************
  nsld_pkg::nsld_selftest_type st_reg; // Current self-test phase
  logic [15:0]                 st_ms_reg; // Ms within phase

  // Green step, red step, then hold until done; reset restarts
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      st_reg    <= nsld_pkg::ST_GREEN; // [RULE17]
      st_ms_reg <= nsld_pkg::MS_COUNT_RESET;
    end
    else
    begin
      case (st_reg)
        nsld_pkg::ST_GREEN, nsld_pkg::ST_RED:
        begin
          // Step through the two timed colours
          if (ms_tick && st_ms_reg == STEP_LAST)
          begin
            st_ms_reg <= nsld_pkg::MS_COUNT_RESET;
            st_reg    <= (st_reg == nsld_pkg::ST_GREEN) ? nsld_pkg::ST_RED
                                                        : nsld_pkg::ST_HOLD;
          end
          else if (ms_tick)
            st_ms_reg <= st_ms_reg + 16'h0001;
        end
        nsld_pkg::ST_HOLD:
        begin
          // Hold final colours until the test reports done
          if (done_s)
            st_reg <= nsld_pkg::ST_DONE;
        end
        nsld_pkg::ST_DONE:
          st_reg <= nsld_pkg::ST_DONE;
        default:
          st_reg <= nsld_pkg::ST_GREEN;
      endcase
    end
  end

  // ****************************************************************
  // 1 Hz flash phase
  // ****************************************************************
  logic [15:0] flash_ms_reg; // Ms within flash half
  logic        flash_on_reg; // Lit half of flash

  // 500 ms lit then 500 ms dark, free running
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      flash_ms_reg <= nsld_pkg::MS_COUNT_RESET;
      flash_on_reg <= 1'b1;
    end
    else if (ms_tick && flash_ms_reg == FLASH_LAST)
    begin
      flash_ms_reg <= nsld_pkg::MS_COUNT_RESET;
      flash_on_reg <= ~flash_on_reg; // [RULE15]
    end
    else if (ms_tick)
      flash_ms_reg <= flash_ms_reg + 16'h0001;
  end

  // ****************************************************************
  // Module health lamp
  // ****************************************************************
  nsld_pkg::nsld_duo_type mod_next; // Next module lamp value

  // Self-test first, then faults, then standby and operational
  always_comb
  begin
    mod_next = nsld_pkg::DUO_OFF;
    case (st_reg)
      nsld_pkg::ST_GREEN: mod_next = nsld_pkg::DUO_GREEN; // [RULE3]
      nsld_pkg::ST_RED:   mod_next = nsld_pkg::DUO_RED;   // [RULE3]
      nsld_pkg::ST_HOLD:  mod_next = nsld_pkg::DUO_GREEN; // [RULE3]
      default:
      begin
        if (mod_s.unrecoverable_fault)
          mod_next = nsld_pkg::DUO_RED; // [RULE6]
        else if (mod_s.recoverable_fault)
          mod_next = flash_on_reg ? nsld_pkg::DUO_RED : nsld_pkg::DUO_OFF; // [RULE5]
        else if (mod_s.unconfigured)
          mod_next = flash_on_reg ? nsld_pkg::DUO_GREEN : nsld_pkg::DUO_OFF; // [RULE2]
        else if (mod_s.operational)
          mod_next = nsld_pkg::DUO_GREEN; // [RULE1]
      end
    endcase
  end

  // ****************************************************************
  // Network health lamp
  // ****************************************************************
  nsld_pkg::nsld_duo_type net_next; // Next network lamp value

  // Fixed precedence over network conditions
  always_comb
  begin
    net_next = nsld_pkg::DUO_OFF;
    case (st_reg)
      nsld_pkg::ST_GREEN: net_next = nsld_pkg::DUO_GREEN; // [RULE4]
      nsld_pkg::ST_RED:   net_next = nsld_pkg::DUO_RED;   // [RULE4]
      nsld_pkg::ST_HOLD:  net_next = nsld_pkg::DUO_OFF;   // [RULE4]
      default:
      begin
        if (net_s.duplicate_ip)
          net_next = nsld_pkg::DUO_RED; // [RULE11] [RULE18]
        else if (!net_s.ip_configured)
          net_next = nsld_pkg::DUO_OFF; // [RULE12]
        else if (net_s.owner_timeout)
          // Held until every timed-out owner is back
          net_next = flash_on_reg ? nsld_pkg::DUO_RED : nsld_pkg::DUO_OFF; // [RULE9] [RULE10]
        else if (net_s.connection_open)
          net_next = nsld_pkg::DUO_GREEN; // [RULE7]
        else
          net_next = flash_on_reg ? nsld_pkg::DUO_GREEN : nsld_pkg::DUO_OFF; // [RULE8]
      end
    endcase
  end

  // ****************************************************************
  // Activity flicker
  // ****************************************************************
  logic [15:0] flick_ms_reg; // Ms within flicker half
  logic        flick_busy;   // Toggle running
  logic        pending_reg;  // Activity seen since last toggle

  assign flick_busy = activity_lamp_out || pending_reg;

  // Catch activity; toggle lamp every 50 ms while traffic lasts
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      flick_ms_reg      <= nsld_pkg::MS_COUNT_RESET;
      pending_reg       <= 1'b0;
      activity_lamp_out <= 1'b0;
    end
    else if (!flick_busy)
    begin
      // Idle and dark: light at once on first frame
      flick_ms_reg <= nsld_pkg::MS_COUNT_RESET;
      if (act_s)
        activity_lamp_out <= 1'b1; // [RULE14]
    end
    else
    begin
      if (act_s && activity_lamp_out)
        pending_reg <= 1'b1; // Cannot coincide with the clear below
      if (ms_tick && flick_ms_reg == FLICKER_LAST)
      begin
        flick_ms_reg      <= nsld_pkg::MS_COUNT_RESET;
        activity_lamp_out <= ~activity_lamp_out; // [RULE16]
        if (!activity_lamp_out && !act_s)
          pending_reg <= 1'b0;
        if (!activity_lamp_out && !pending_reg)
          activity_lamp_out <= 1'b0; // [RULE14]
      end
      else if (ms_tick)
        flick_ms_reg <= flick_ms_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      module_health_lamp_out  <= nsld_pkg::DUO_OFF;
      network_health_lamp_out <= nsld_pkg::DUO_OFF;
      link_lamp_out           <= 1'b0;
    end
    else
    begin
      module_health_lamp_out  <= mod_next;
      network_health_lamp_out <= net_next;
      link_lamp_out           <= link_s; // [RULE13]
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_link_follow; // [RULE13]
    @(posedge clock_in) disable iff (!reset_n_in)
      link_reg |=> link_lamp_out;
  endproperty
  a_link_follow: assert property (p_link_follow) else $error("link lamp not lit");

  property p_dup_red; // [RULE11]
    @(posedge clock_in) disable iff (!reset_n_in)
      (st_reg == nsld_pkg::ST_DONE && net_s.duplicate_ip)
        |=> network_health_lamp_out == nsld_pkg::DUO_RED;
  endproperty
  a_dup_red: assert property (p_dup_red) else $error("duplicate address not red");

  property p_noip_dark; // [RULE12]
    @(posedge clock_in) disable iff (!reset_n_in)
      (st_reg == nsld_pkg::ST_DONE && !net_s.ip_configured)
        |=> network_health_lamp_out.green == 1'b0;
  endproperty
  a_noip_dark: assert property (p_noip_dark) else $error("network lit without address");

  property p_fault_red; // [RULE6]
    @(posedge clock_in) disable iff (!reset_n_in)
      (st_reg == nsld_pkg::ST_DONE && mod_s.unrecoverable_fault)
        |=> module_health_lamp_out == nsld_pkg::DUO_RED;
  endproperty
  a_fault_red: assert property (p_fault_red) else $error("fault not red");

  sequence s_red_step;
    st_reg == nsld_pkg::ST_RED;
  endsequence
  property p_green_then_red; // [RULE3]
    @(posedge clock_in) disable iff (!reset_n_in)
      (st_reg == nsld_pkg::ST_GREEN ##1 s_red_step)
        |=> module_health_lamp_out == nsld_pkg::DUO_RED;
  endproperty
  a_green_then_red: assert property (p_green_then_red) else $error("self-test order wrong");

  property p_hold_net_dark; // [RULE4]
    @(posedge clock_in) disable iff (!reset_n_in)
      st_reg == nsld_pkg::ST_HOLD |=> network_health_lamp_out == nsld_pkg::DUO_OFF;
  endproperty
  a_hold_net_dark: assert property (p_hold_net_dark) else $error("network lit in hold");

  property p_flash_stable; // [RULE15]
    @(posedge clock_in) disable iff (!reset_n_in)
      !ms_tick |=> $stable(flash_on_reg);
  endproperty
  a_flash_stable: assert property (p_flash_stable) else $error("flash changed off tick");

  property p_oper_green; // [RULE1]
    @(posedge clock_in) disable iff (!reset_n_in)
      (st_reg == nsld_pkg::ST_DONE && mod_s == 4'h8)
        |=> module_health_lamp_out == nsld_pkg::DUO_GREEN;
  endproperty
  a_oper_green: assert property (p_oper_green) else $error("operational not green");

endmodule

// ### nsld_lamp_panel.sv
// Operator's view of the lamps: run-length meters for the module, network and activity lamps
`timescale 1ns/1ns

// ****************************************************************
// One lamp meter
// ****************************************************************
module nsld_run_meter #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clock_in,
  input  wire logic             clear_in,
  input  wire logic [WIDTH-1:0] lamp_in,
  output logic      [WIDTH-1:0] seen_out,
  output int                    run_out,
  output int                    last_out,
  output int                    changes_out
);
  logic [WIDTH-1:0] prev_reg;  // Lamp value one edge ago
  logic             change;    // Lamp differs from last edge

  assign change = (lamp_in !== prev_reg);

  // Run length of the current colour and of the one before
  always_ff @(posedge clock_in)
  begin
    prev_reg <= lamp_in;
    if (change)
    begin
      last_out <= run_out + 1;
      run_out  <= 0;
    end
    else
    begin
      run_out <= run_out + 1;
    end
  end

  // Colours seen and changes counted since the last clear
  always_ff @(posedge clock_in)
  begin
    if (clear_in)
    begin
      seen_out    <= lamp_in;
      changes_out <= 0;
    end
    else
    begin
      seen_out    <= seen_out | lamp_in;
      changes_out <= changes_out + (change ? 1 : 0);
    end
  end
endmodule

// ****************************************************************
// Panel of three lamps as an operator sees them
// ****************************************************************
module nsld_lamp_panel (
  input  wire logic                   clock_in,
  input  wire logic                   clear_in,
  input  wire nsld_pkg::nsld_duo_type module_lamp_in,
  input  wire nsld_pkg::nsld_duo_type network_lamp_in,
  input  wire logic                   activity_lamp_in,
  output logic [1:0]                  mod_seen_out,
  output int                          mod_last_out,
  output int                          mod_changes_out,
  output logic [1:0]                  net_seen_out,
  output int                          net_last_out,
  output int                          net_changes_out,
  output int                          act_last_out,
  output int                          act_changes_out
);
  nsld_run_meter #(.WIDTH(2)) mod_meter (.clock_in(clock_in), .clear_in(clear_in),
    .lamp_in(module_lamp_in), .seen_out(mod_seen_out), .run_out(),
    .last_out(mod_last_out), .changes_out(mod_changes_out));
  nsld_run_meter #(.WIDTH(2)) net_meter (.clock_in(clock_in), .clear_in(clear_in),
    .lamp_in(network_lamp_in), .seen_out(net_seen_out), .run_out(),
    .last_out(net_last_out), .changes_out(net_changes_out));
  nsld_run_meter #(.WIDTH(1)) act_meter (.clock_in(clock_in), .clear_in(clear_in),
    .lamp_in(activity_lamp_in), .seen_out(), .run_out(),
    .last_out(act_last_out), .changes_out(act_changes_out));
endmodule

// ### nsld_pkg.sv
// Package of shared constants and types for the network status lamp driver
package nsld_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLOCK_HZ          = 50_000_000;       // System clock rate
  localparam int unsigned TICK_TIME_US      = 1000;             // Timebase period in us
  localparam int unsigned TICK_CYCLES       = CLOCK_HZ / 1_000_000 * TICK_TIME_US; // Per tick
  localparam int unsigned SELFTEST_STEP_MS  = 250;              // Self-test colour step
  localparam int unsigned FLASH_HALF_MS     = 500;              // 1 Hz half period
  localparam int unsigned FLICKER_HALF_MS   = 50;               // Activity half period
  localparam logic [15:0] MS_COUNT_RESET    = 16'h0000;         // Counter value after reset

  // ****************************************************************
  // Types
  // ****************************************************************
  // Two-colour lamp drive
  typedef struct packed {
    logic red;
    logic green;
  } nsld_duo_type;

  localparam nsld_duo_type DUO_OFF   = 2'h0; // Dark
  localparam nsld_duo_type DUO_GREEN = 2'h1; // Green only
  localparam nsld_duo_type DUO_RED   = 2'h2; // Red only

  // Module condition flags
  typedef struct packed {
    logic operational;
    logic unconfigured;
    logic recoverable_fault;
    logic unrecoverable_fault;
  } nsld_module_type;

  // Network condition flags
  typedef struct packed {
    logic ip_configured;
    logic connection_open;
    logic owner_timeout;
    logic duplicate_ip;
  } nsld_network_type;

  // Self-test phases
  typedef enum logic [1:0] {
    ST_GREEN = 2'b00,
    ST_RED   = 2'b01,
    ST_HOLD  = 2'b10,
    ST_DONE  = 2'b11
  } nsld_selftest_type;

endpackage

// ### nsld_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module nsld_sync #(
  parameter int unsigned WIDTH = 10
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  initial
  begin
    if (WIDTH < 1)
      $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage1_reg; // First stage, read only by second

  // ****************************************************************
  // Two flops
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// ### nsld_tick_divider.sv
// Divider that makes a one-cycle timebase tick from the system clock
`timescale 1ns/1ns
module nsld_tick_divider #(
  parameter int unsigned DIVIDE = nsld_pkg::TICK_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  output logic      tick_out
);

  // Refuse a divider that cannot count
  initial
  begin
    if (DIVIDE < 2)
      $error("DIVIDE must be at least 2");
  end

  logic [31:0] count_reg; // Cycles since last tick

  // ****************************************************************
  // Counter and tick
  // ****************************************************************
  // Wraps at DIVIDE and pulses tick on the wrap
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= 32'h00000000;
      tick_out  <= 1'b0;
    end
    else if (count_reg == DIVIDE - 1)
    begin
      count_reg <= 32'h00000000;
      tick_out  <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 32'h00000001;
      tick_out  <= 1'b0;
    end
  end

endmodule

// ### tb_top.sv
// Self-checking testbench for the network status lamp driver
`timescale 1ns/1ns
module tb_top;
  // ****************************************************************
  // Shortened timing
  // ****************************************************************
  localparam int TDIV  = 4;            // Cycles per tick
  localparam int STEP  = 3;            // Self-test step in ticks
  localparam int FLASH = 5;            // Flash half in ticks
  localparam int FLICK = 2;            // Flicker half in ticks
  localparam int STEP_CYC  = TDIV * STEP;
  localparam int FLASH_CYC = TDIV * FLASH;
  localparam int FLICK_CYC = TDIV * FLICK;
  localparam int LIMIT = 10000;        // Cycle ceiling for the run

  logic clock_in = 1'b0, reset_n_in = 1'b0, selftest_done_in = 1'b0;
  logic link_up_in = 1'b0, frame_activity_in = 1'b0, meter_clear = 1'b0;
  nsld_pkg::nsld_module_type  module_flags  = 4'h0;
  nsld_pkg::nsld_network_type network_flags = 4'h0;
  nsld_pkg::nsld_duo_type     module_lamp, network_lamp;
  logic       link_lamp, activity_lamp;
  logic [1:0] mod_seen, net_seen;
  int mod_last, mod_chg, net_last, net_chg, act_last, act_chg;
  int err_count = 0, check_count = 0, cycle_count = 0;

  // Free-running 50 MHz clock
  always #10 clock_in = ~clock_in;

  nsld_lamp_driver #(.TICK_DIVIDE(TDIV), .STEP_MS(STEP), .FLASH_MS(FLASH),
    .FLICKER_MS(FLICK)) nsld_lamp_driver_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .selftest_done_in(selftest_done_in),
    .module_in(module_flags), .network_in(network_flags), .link_up_in(link_up_in),
    .frame_activity_in(frame_activity_in), .module_health_lamp_out(module_lamp),
    .network_health_lamp_out(network_lamp), .link_lamp_out(link_lamp),
    .activity_lamp_out(activity_lamp));

  nsld_lamp_panel nsld_lamp_panel_inst (
    .clock_in(clock_in), .clear_in(meter_clear), .module_lamp_in(module_lamp),
    .network_lamp_in(network_lamp), .activity_lamp_in(activity_lamp),
    .mod_seen_out(mod_seen), .mod_last_out(mod_last), .mod_changes_out(mod_chg),
    .net_seen_out(net_seen), .net_last_out(net_last), .net_changes_out(net_chg),
    .act_last_out(act_last), .act_changes_out(act_chg));

  // ****************************************************************
  // Reporting and comparison
  // ****************************************************************
  task automatic close_out();
    $display("errors %0d, checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock_in)
  begin
    cycle_count++;
    if (cycle_count == LIMIT)
    begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic compare_duo(input logic [1:0] act, input logic [1:0] exp, input string what);
    check_count++;
    if (act !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic compare_bit(input logic act, input logic exp, input string what);
    check_count++;
    if (act !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %b want %b", $time, what, act, exp);
    end
  endtask

  task automatic compare_range(input int act, input int lo, input int hi, input string what);
    check_count++;
    if (act < lo || act > hi)
    begin
      err_count++;
      $display("[ERR] %0t %s: got %0d want %0d..%0d", $time, what, act, lo, hi);
    end
  endtask

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic cycles(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // Clear the meters, then watch for a window
  task automatic observe(input int n);
    meter_clear = 1'b1;
    cycles(1);
    meter_clear = 1'b0;
    cycles(n);
  endtask

  // Settle, watch and judge one two-colour lamp
  task automatic judge(input logic net, input logic [1:0] col, input logic flash);
    cycles(8);
    observe(4 * FLASH_CYC);
    compare_duo(net ? net_seen : mod_seen, col, "lamp colour");
    if (flash)
    begin
      compare_range(net ? net_last : mod_last, FLASH_CYC - 1, FLASH_CYC + 1, "flash half");
      compare_range(net ? net_chg : mod_chg, 3, 99, "flash edges");
    end
    else
      compare_range(net ? net_chg : mod_chg, 0, 0, "steady lamp");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset, then the self-test sequence with completion held off
  task automatic test_selftest();
    reset_n_in = 1'b0;
    selftest_done_in = 1'b0;
    cycles(12);
    compare_duo(module_lamp, 2'h0, "module in reset");
    compare_duo(network_lamp, 2'h0, "network in reset");
    meter_clear = 1'b1;
    reset_n_in = 1'b1;
    cycles(1);
    meter_clear = 1'b0;
    cycles(3 * STEP_CYC + 20);
    compare_duo(mod_seen, 2'h3, "module test colours");
    compare_range(mod_last, STEP_CYC - 1, STEP_CYC + 1, "module red step");
    compare_duo(module_lamp, nsld_pkg::DUO_GREEN, "module test hold");
    compare_duo(net_seen, 2'h3, "network test colours");
    compare_range(net_last, STEP_CYC - 1, STEP_CYC + 1, "network red step");
    module_flags = 4'h1;
    network_flags = 4'hF;
    judge(1'b0, nsld_pkg::DUO_GREEN, 1'b0);
    compare_duo(network_lamp, nsld_pkg::DUO_OFF, "network test dark");
    selftest_done_in = 1'b1;
  endtask

  // Module lamp for each condition and their priority
  task automatic test_module();
    module_flags = 4'h8;
    judge(1'b0, nsld_pkg::DUO_GREEN, 1'b0);
    module_flags = 4'h4;
    judge(1'b0, nsld_pkg::DUO_GREEN, 1'b1);
    module_flags = 4'h2;
    judge(1'b0, nsld_pkg::DUO_RED, 1'b1);
    module_flags = 4'h1;
    judge(1'b0, nsld_pkg::DUO_RED, 1'b0);
    module_flags = 4'hF;
    judge(1'b0, nsld_pkg::DUO_RED, 1'b0);
  endtask

  // Network lamp for each condition, precedence and recovery
  task automatic test_network();
    network_flags = 4'h0;
    judge(1'b1, nsld_pkg::DUO_OFF, 1'b0);
    network_flags = 4'h8;
    judge(1'b1, nsld_pkg::DUO_GREEN, 1'b1);
    network_flags = 4'hC;
    judge(1'b1, nsld_pkg::DUO_GREEN, 1'b0);
    network_flags = 4'hE;
    judge(1'b1, nsld_pkg::DUO_RED, 1'b1);
    network_flags = 4'hF;
    judge(1'b1, nsld_pkg::DUO_RED, 1'b0);
    network_flags = 4'hE;
    judge(1'b1, nsld_pkg::DUO_RED, 1'b1);
    network_flags = 4'hC;
    judge(1'b1, nsld_pkg::DUO_GREEN, 1'b0);
    network_flags = 4'h6;
    judge(1'b1, nsld_pkg::DUO_OFF, 1'b0);
  endtask

  // Link lamp follows the link
  task automatic test_link();
    link_up_in = 1'b1;
    cycles(5);
    compare_bit(link_lamp, 1'b1, "link up");
    link_up_in = 1'b0;
    cycles(5);
    compare_bit(link_lamp, 1'b0, "link down");
  endtask

  // Activity lamp under a single frame, heavy load and silence
  task automatic test_activity();
    frame_activity_in = 1'b1;
    cycles(1);
    frame_activity_in = 1'b0;
    cycles(5);
    compare_bit(activity_lamp, 1'b1, "single frame");
    cycles(4 * FLICK_CYC);
    frame_activity_in = 1'b1;
    observe(10 * FLICK_CYC);
    compare_range(act_chg, 8, 11, "flicker edges");
    compare_range(act_last, FLICK_CYC - 1, FLICK_CYC + 1, "flicker half");
    frame_activity_in = 1'b0;
    cycles(4 * FLICK_CYC);
    observe(5 * FLICK_CYC);
    compare_bit(activity_lamp, 1'b0, "quiet lamp");
    compare_range(act_chg, 0, 0, "quiet edges");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    test_selftest();
    test_module();
    test_network();
    test_link();
    test_activity();
    test_selftest();
    close_out();
  end
endmodule
